/* File: logic/tcc_channel0.sv */
// channel 0 capture/compare register with its 16-bit counter
// Function
// - the register can be chosen as capture only in free-running mode by the select bit; pulse-width mode always captures, other modes compare.
// - the register is read and written as a whole 16-bit word while the timer runs.
// - reset leaves the register at zero.
// - compare writes are taken even while the run enable bit is one.
// - written values move to a compare buffer and a counter match raises the match interrupt.
// - on a match the output pin toggles when its output is enabled.
// - in interval, event, trigger, one-shot and PWM modes a match clears the counter.
// - in free-running capture use a valid input edge latches the counter into the register.
// - in pulse-width mode a valid edge latches the counter and clears it.
// - a read that meets a capture returns a whole, uncorrupted value.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module tcc_channel0
	import tcc_pkg::*;
#(
	parameter int CNT_W = 16
)(
	input  wire logic              i_mclk,    // system clock, 250 MHz
	input  wire logic              i_sys_rst, // sync reset, active high
	input  wire logic [ADDR_W-1:0] i_addr,    // register byte address
	input  wire logic [DATA_W-1:0] i_wdata,   // write data
	input  wire logic              i_wr,      // write strobe
	input  wire logic              i_rd,      // read strobe
	input  wire logic              i_capt_pin, // capture input pin
	output logic      [DATA_W-1:0] o_rdata,   // read data, cycle after i_rd
	output logic                   o_match,   // match interrupt request pulse
	output logic                   o_out_pin, // timer output pin level
	output logic                   o_irq      // masked interrupt level
);
	logic [CNT_W-1:0]  ccr_reg;
	logic [CNT_W-1:0]  buf_reg;
	logic              pend_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [ST_W-1:0]   status_reg;
	logic [ST_W-1:0]   mask_reg;
	logic              edge_det;
	logic              run;
	logic [MODE_W-1:0] mode;
	logic              capt_use;
	logic              is_match;
	logic              is_capt;
	logic              boundary;
	logic              clr_mode;
	logic [ST_W-1:0]   st_set;

	// three-flop synchroniser lives in the edge detector
	tcc_edge_detect u_edge (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_pin     (i_capt_pin),
		.i_edge_sel(ctrl_reg[CTRL_EDGE +: EDGE_W]),
		.o_edge    (edge_det)
	);

	function automatic logic clears_on_match(input logic [MODE_W-1:0] m);
		clears_on_match = (m == MODE_INTERVAL) || (m == MODE_EXTEVENT)
			|| (m == MODE_EXTTRIG) || (m == MODE_ONESHOT) || (m == MODE_PWM);
	endfunction

	function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
		wr_hit = (a == o);
	endfunction

	assign run  = ctrl_reg[CTRL_RUN];
	assign mode = ctrl_reg[CTRL_MODE +: MODE_W];
	// capture use only in free-running with select, or pulse-width
	assign capt_use = ((mode == MODE_FREERUN) && ctrl_reg[CTRL_CSEL])
		|| (mode == MODE_PULSEW);
	assign clr_mode = clears_on_match(mode);
	assign is_match = run && !capt_use && (cnt_reg == buf_reg);
	assign is_capt  = run && capt_use && edge_det;
	// boundary where a pending value may enter the buffer
	assign boundary = is_match || (cnt_reg == CNT_MAX[CNT_W-1:0]) || !run;
	assign st_set   = {is_capt, is_match};

	// counter: cleared by match in cycle modes, by capture in pulse-width
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			cnt_reg <= CNT_ZERO[CNT_W-1:0];
		end else if (!run) begin
			cnt_reg <= CNT_ZERO[CNT_W-1:0];
		end else if (is_match && clr_mode) begin
			cnt_reg <= CNT_ZERO[CNT_W-1:0];
		end else if (is_capt && mode == MODE_PULSEW) begin
			cnt_reg <= CNT_ZERO[CNT_W-1:0];
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// capture/compare register; capture beats a same-cycle write
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ccr_reg <= CCR_RST[CNT_W-1:0];
		end else if (is_capt) begin
			ccr_reg <= cnt_reg;
		end else if (i_wr && wr_hit(i_addr, OFS_CCR)) begin
			ccr_reg <= i_wdata[CNT_W-1:0];
		end
	end

	// buffer reloads only at a boundary so a compare never sees a half value
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			buf_reg  <= CCR_RST[CNT_W-1:0];
			pend_reg <= 1'b0;
		end else begin
			if (i_wr && wr_hit(i_addr, OFS_CCR) && !boundary) begin
				pend_reg <= 1'b1;
			end else if (boundary) begin
				pend_reg <= 1'b0;
			end
			if (boundary && (pend_reg || (i_wr && wr_hit(i_addr, OFS_CCR)))) begin
				buf_reg <= (i_wr && wr_hit(i_addr, OFS_CCR)) ? i_wdata[CNT_W-1:0]
					: ccr_reg;
			end
		end
	end

	// control and mask registers
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ctrl_reg <= '0;
			mask_reg <= '0;
		end else if (i_wr) begin
			if (wr_hit(i_addr, OFS_CTRL)) begin
				ctrl_reg <= i_wdata[CTRL_W-1:0];
			end else if (wr_hit(i_addr, OFS_MASK)) begin
				mask_reg <= i_wdata[ST_W-1:0];
			end
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			status_reg <= '0;
		end else if (i_wr && wr_hit(i_addr, OFS_STATUS)) begin
			status_reg <= (status_reg & ~i_wdata[ST_W-1:0]) | st_set;
		end else begin
			status_reg <= status_reg | st_set;
		end
	end

	// match pulse and output toggle
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_match   <= 1'b0;
			o_out_pin <= 1'b0;
		end else begin
			o_match <= is_match;
			if (is_match && ctrl_reg[CTRL_OE]) begin
				o_out_pin <= !o_out_pin;
			end
		end
	end

	// registered level, so the interrupt line never glitches
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_reg & mask_reg);
		end
	end

	// read data sampled whole at the strobe edge, so a capture never tears it
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			if (i_addr == OFS_CCR) begin
				o_rdata <= DATA_W'(ccr_reg);
			end else if (i_addr == OFS_CTRL) begin
				o_rdata <= DATA_W'(ctrl_reg);
			end else if (i_addr == OFS_STATUS) begin
				o_rdata <= DATA_W'(status_reg);
			end else if (i_addr == OFS_MASK) begin
				o_rdata <= DATA_W'(mask_reg);
			end else if (i_addr == OFS_COUNT) begin
				o_rdata <= DATA_W'(cnt_reg);
			end else begin
				o_rdata <= '0;
			end
		end else begin
			o_rdata <= '0;
		end
	end

	// checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	// outside capture use only a bus write may move the register
	property p_sel_mode;
		((mode != MODE_FREERUN || !ctrl_reg[CTRL_CSEL]) && mode != MODE_PULSEW
			&& !(i_wr && i_addr == OFS_CCR)) |=> $stable(ccr_reg);
	endproperty
	a_sel_mode: assert property (p_sel_mode) else $error("capture outside capture mode");

	property p_ccr_write;
		(i_wr && i_addr == OFS_CCR && !is_capt) |=> (ccr_reg == $past(i_wdata));
	endproperty
	a_ccr_write: assert property (p_ccr_write) else $error("ccr write lost");

	property p_reset_zero;
		$past(i_sys_rst) |-> (ccr_reg == CCR_RST);
	endproperty
	a_reset_zero: assert property (@(posedge i_mclk) p_reset_zero)
		else $error("ccr not zero after reset");

	property p_run_write;
		(run && !capt_use && i_wr && i_addr == OFS_CCR) |=> (ccr_reg == $past(i_wdata));
	endproperty
	a_run_write: assert property (p_run_write) else $error("write refused while running");

	// zero in the buffer of a clearing mode matches every cycle, so no low follows
	property p_match_pulse;
		(run && !capt_use && cnt_reg == buf_reg) |=> o_match;
	endproperty
	a_match_pulse: assert property (p_match_pulse) else $error("match pulse wrong");

	property p_match_quiet;
		!(run && !capt_use && cnt_reg == buf_reg) |=> !o_match;
	endproperty
	a_match_quiet: assert property (p_match_quiet) else $error("stray match pulse");

	property p_match_status;
		is_match |=> status_reg[ST_MATCH];
	endproperty
	a_match_status: assert property (p_match_status) else $error("match status not set");

	property p_capt_no_match;
		(run && capt_use) |=> !o_match;
	endproperty
	a_capt_no_match: assert property (p_capt_no_match) else $error("match in capture use");

	property p_toggle;
		(is_match && ctrl_reg[CTRL_OE]) |=> (o_out_pin != $past(o_out_pin));
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin did not toggle");

	property p_pin_hold;
		!(is_match && ctrl_reg[CTRL_OE]) |=> $stable(o_out_pin);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin moved without match");

	property p_clear;
		(is_match && clr_mode) |=> (cnt_reg == CNT_ZERO);
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared on match");

	// free-running compare keeps counting through a match
	property p_free_count;
		(is_match && !clr_mode) |=> (cnt_reg == $past(cnt_reg) + 1'b1);
	endproperty
	a_free_count: assert property (p_free_count) else $error("free-run count cleared");

	property p_stop_hold;
		!run |=> (cnt_reg == CNT_ZERO);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stopped counter not at zero");

	property p_count_step;
		(run && !is_match && !is_capt) |=> (cnt_reg == $past(cnt_reg) + 1'b1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter missed a step");

	property p_capture;
		is_capt |=> (ccr_reg == $past(cnt_reg)) && status_reg[ST_CAPT];
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_pw_clear;
		(is_capt && mode == MODE_PULSEW) |=> (cnt_reg == CNT_ZERO);
	endproperty
	a_pw_clear: assert property (p_pw_clear) else $error("pulse-width clear missing");

	property p_read;
		(i_rd && i_addr == OFS_CCR) |=> (o_rdata == DATA_W'($past(ccr_reg)));
	endproperty
	a_read: assert property (p_read) else $error("ccr read corrupted");

	// read data stand one cycle only, then fall back to zero
	property p_rdata_idle;
		!i_rd |=> (o_rdata == '0);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

	property p_irq;
		1'b1 |=> (o_irq == $past(|(status_reg & mask_reg)));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not following masked status");

	property p_status_w1c;
		(i_wr && i_addr == OFS_STATUS && i_wdata[ST_MATCH] && !is_match)
			|=> !status_reg[ST_MATCH];
	endproperty
	a_status_w1c: assert property (p_status_w1c) else $error("match status not cleared");

	property p_ctrl_write;
		(i_wr && i_addr == OFS_CTRL) |=> (ctrl_reg == $past(i_wdata[CTRL_W-1:0]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_mask_write;
		(i_wr && i_addr == OFS_MASK) |=> (mask_reg == $past(i_wdata[ST_W-1:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_reload;
		(pend_reg && boundary) |=> (buf_reg == ($past(i_wr && i_addr == OFS_CCR)
			? $past(i_wdata[CNT_W-1:0]) : $past(ccr_reg)));
	endproperty
	a_reload: assert property (p_reload) else $error("buffer missed boundary");

	property p_buf_direct;
		(boundary && i_wr && i_addr == OFS_CCR)
			|=> (buf_reg == $past(i_wdata[CNT_W-1:0]));
	endproperty
	a_buf_direct: assert property (p_buf_direct) else $error("boundary write lost");

	// between boundaries the compare value must not move
	property p_buf_hold;
		!boundary |=> $stable(buf_reg);
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("buffer moved off a boundary");

	property p_pend;
		(i_wr && i_addr == OFS_CCR && !boundary) |=> pend_reg;
	endproperty
	a_pend: assert property (p_pend) else $error("write not held for the boundary");

	c_match: cover property (is_match && ctrl_reg[CTRL_OE]);
	c_capt_read: cover property (is_capt && i_rd && i_addr == OFS_CCR);
	c_pw: cover property (is_capt && mode == MODE_PULSEW);
	c_irq: cover property (o_irq);
	c_reload: cover property (pend_reg && boundary);
endmodule

/* File: logic/tcc_edge_detect.sv */
// capture input synchroniser and valid edge detector
`timescale 1ns/10ps
module tcc_edge_detect
	import tcc_pkg::*;
(
	input  wire logic              i_mclk,     // system clock
	input  wire logic              i_sys_rst,  // sync reset, active high
	input  wire logic              i_pin,      // asynchronous capture pin
	input  wire logic [EDGE_W-1:0] i_edge_sel, // valid edge selection
	output logic                   o_edge      // one-cycle valid edge pulse
);
	logic       sync1_reg;
	logic       sync2_reg;
	logic       sync3_reg;
	logic       level_reg;
	logic       rise;
	logic       fall;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= i_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// a change counts only once stages two and three agree
	assign rise = (sync2_reg == sync3_reg) && sync3_reg && !level_reg;
	assign fall = (sync2_reg == sync3_reg) && !sync3_reg && level_reg;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			level_reg <= 1'b0;
			o_edge    <= 1'b0;
		end else begin
			if (rise || fall) begin
				level_reg <= sync3_reg;
			end
			o_edge <= (rise && (i_edge_sel == EDGE_RISE || i_edge_sel == EDGE_BOTH))
				|| (fall && (i_edge_sel == EDGE_FALL || i_edge_sel == EDGE_BOTH));
		end
	end
endmodule

/* File: shared/tcc_pkg.sv */
// constants for the channel 0 capture/compare block
package tcc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// register byte offsets
	localparam logic [7:0] OFS_CCR    = 8'h00;
	localparam logic [7:0] OFS_CTRL   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK   = 8'h0C;
	localparam logic [7:0] OFS_COUNT  = 8'h10;
	// reset values and counter top
	localparam logic [15:0] CCR_RST  = 16'h0000;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	// control field positions
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_MODE  = 1;
	localparam int MODE_W     = 3;
	localparam int CTRL_CSEL  = 4;
	localparam int CTRL_OE    = 5;
	localparam int CTRL_EDGE  = 6;
	localparam int EDGE_W     = 2;
	localparam int CTRL_W     = 8;
	// status and mask bit positions
	localparam int ST_MATCH = 0;
	localparam int ST_CAPT  = 1;
	localparam int ST_W     = 2;
	// operating modes
	localparam logic [2:0] MODE_INTERVAL = 3'h0;
	localparam logic [2:0] MODE_EXTEVENT = 3'h1;
	localparam logic [2:0] MODE_EXTTRIG  = 3'h2;
	localparam logic [2:0] MODE_ONESHOT  = 3'h3;
	localparam logic [2:0] MODE_PWM      = 3'h4;
	localparam logic [2:0] MODE_FREERUN  = 3'h5;
	localparam logic [2:0] MODE_PULSEW   = 3'h6;
	// valid edge selections
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

/* File: test/tcc_channel0_bench.sv */
// register-level tests of the channel 0 capture/compare block
`timescale 1ns/10ps
module tcc_channel0_bench;
	import tcc_pkg::*;
	logic              i_mclk, i_sys_rst, i_wr, i_rd, pin_level, capt_pin;
	logic              o_match, o_out_pin, o_irq;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata, rd_val, c0, cap;
	logic [DATA_W-1:0] seen_q [6];
	int                failures, comparisons, n;

	tcc_channel0 #(.CNT_W(16)) tcc_channel0_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_capt_pin(capt_pin),
		.o_rdata(o_rdata), .o_match(o_match), .o_out_pin(o_out_pin), .o_irq(o_irq));
	tcc_pin_source tcc_pin_source_inst (.i_mclk(i_mclk), .i_level(pin_level), .o_pin(capt_pin));

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// one idle cycle after each access keeps strobes from being assigned twice
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		d = o_rdata;
		@(posedge i_mclk);
	endtask

	// cycles until the next match pulse, bounded
	task automatic wait_match(output int cnt);
		cnt = 0;
		do begin
			@(negedge i_mclk);
			cnt++;
		end while (o_match !== 1'b1 && cnt < 300);
		@(posedge i_mclk);
	endtask

	initial begin
		i_sys_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		pin_level = 1'b0;
		failures = 0;
		comparisons = 0;
		repeat (2) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		@(posedge i_mclk);
		rd(OFS_CCR, rd_val);
		check("ccr reset", rd_val, CCR_RST);
		check("irq reset", {15'h0, o_irq}, 16'h0000);
		rd(8'h40, rd_val);
		check("unmapped read", rd_val, 16'h0000);
		wr(OFS_MASK, 16'h0001);
		// every clearing mode: match at 16 gives a 17-cycle period
		for (int m = 0; m < 5; m++) begin
			wr(OFS_CTRL, 16'h0000);
			wr(OFS_CCR, 16'h0010);
			wr(OFS_CTRL, {10'h000, 1'b1, 1'b0, m[2:0], 1'b1});
			wait_match(n);
			check("pin after match", {15'h0, o_out_pin}, 16'h0001);
			wait_match(n);
			check("period", 16'(n), 16'h0011);
			check("pin toggled back", {15'h0, o_out_pin}, 16'h0000);
			// irq rises on the edge after the match pulse, so look mid-cycle
			@(negedge i_mclk);
			check("irq on match", {15'h0, o_irq}, 16'h0001);
			@(posedge i_mclk);
		end
		// rewrite while running: old value finishes its period first
		wait_match(n);
		wr(OFS_CCR, 16'h0020);
		wait_match(n);
		check("period before reload", 16'(n), 16'h000F);
		wait_match(n);
		check("period after reload", 16'(n), 16'h0021);
		rd(OFS_CCR, rd_val);
		check("ccr readback running", rd_val, 16'h0020);
		wr(OFS_CTRL, 16'h0000);
		rd(OFS_STATUS, rd_val);
		check("match status", rd_val, 16'h0001);
		wr(OFS_STATUS, 16'h0001);
		rd(OFS_STATUS, rd_val);
		check("status cleared", rd_val, 16'h0000);
		check("irq cleared", {15'h0, o_irq}, 16'h0000);
		// free-running compare does not clear the counter
		wr(OFS_CCR, 16'h0010);
		wr(OFS_CTRL, 16'h000B);
		wait_match(n);
		rd(OFS_COUNT, rd_val);
		check("free-run keeps count", {15'h0, rd_val > 16'h0010}, 16'h0001);
		// free-running capture on a rising edge, reads racing the capture
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_CCR, 16'h1234);
		wr(OFS_MASK, 16'h0002);
		wr(OFS_CTRL, 16'h005B);
		rd(OFS_COUNT, c0);
		check("no irq before capture", {15'h0, o_irq}, 16'h0000);
		pin_level <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			rd(OFS_CCR, seen_q[k]);
		end
		cap = seen_q[5];
		check("capture window", {15'h0, cap > c0 + 16'h0002 && cap < c0 + 16'h000E}, 16'h0001);
		for (int k = 0; k < 6; k++) begin
			check("whole ccr", {15'h0, seen_q[k] == 16'h1234 || seen_q[k] == cap}, 16'h0001);
		end
		check("capture irq", {15'h0, o_irq}, 16'h0001);
		// compare-only mode ignores the select bit and the pin
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_CCR, 16'h4321);
		wr(OFS_CTRL, 16'h00D1);
		pin_level <= 1'b0;
		repeat (12) @(posedge i_mclk);
		rd(OFS_CCR, rd_val);
		check("no capture outside free-run", rd_val, 16'h4321);
		// pulse-width: capture then restart from zero
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_CTRL, 16'h00CD);
		repeat (50) @(posedge i_mclk);
		pin_level <= 1'b1;
		repeat (12) @(posedge i_mclk);
		rd(OFS_CCR, cap);
		rd(OFS_COUNT, rd_val);
		check("pulse width captured", {15'h0, cap > 16'h0032 && cap < 16'h0040}, 16'h0001);
		check("counter cleared", {15'h0, rd_val < cap}, 16'h0001);
		// falling edge only: the fall captures, the following rise does not
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_CTRL, 16'h009B);
		rd(OFS_CTRL, rd_val);
		check("ctrl readback", rd_val, 16'h009B);
		pin_level <= 1'b0;
		repeat (12) @(posedge i_mclk);
		rd(OFS_CCR, cap);
		check("fall capture", {15'h0, cap > 16'h0002 && cap < 16'h000E}, 16'h0001);
		pin_level <= 1'b1;
		repeat (12) @(posedge i_mclk);
		rd(OFS_CCR, rd_val);
		check("rise ignored", rd_val, cap);
		rd(OFS_MASK, rd_val);
		check("mask readback", rd_val, 16'h0002);
		report_and_stop();
	end

	initial begin
		repeat (5000) @(posedge i_mclk);
		failures++;
		report_and_stop();
	end
endmodule

/* File: test/tcc_pin_source.sv */
// capture pin source that moves the pin away from the sampling edge
`timescale 1ns/10ps
module tcc_pin_source (
	input  wire logic i_mclk,  // system clock
	input  wire logic i_level, // pin level asked for by the bench
	output logic      o_pin    // pin seen by the channel
);
	// the real pin is asynchronous, so it changes mid-cycle
	initial o_pin = 1'b0;
	always @(negedge i_mclk) begin
		o_pin <= i_level;
	end
endmodule
